// file: include/ivpm_pkg.sv
// shared constants and carriers of the interrupt vector and priority map
package ivpm_pkg;

	// ****************************************************************
	// priority storage layout
	// ****************************************************************
	localparam int LINE_COUNT = 32;
	localparam int PRIORITY_BIT_COUNT = 2;
	localparam int SLOT_WIDTH = 8;
	localparam int SLOTS_PER_WORD = 4;
	localparam int PRIO_WORDS = 8;
	localparam int PRIO_MSB = 7;
	localparam int PRIO_LSB = 6;
	localparam logic [31:0] PRIO_WORD_MASK = 32'hC0C0C0C0;
	localparam logic [1:0] PRIO_RESET_VALUE = 2'h0;

	// ****************************************************************
	// vector table
	// ****************************************************************
	localparam int EXC_NUM_WIDTH = 6;
	localparam logic [5:0] EXC_COUNT = 6'h30;
	localparam logic [5:0] EXC_STACK = 6'h00;
	localparam logic [5:0] EXC_RESET = 6'h01;
	localparam logic [5:0] EXC_NMI = 6'h02;
	localparam logic [5:0] EXC_HARD_FAULT = 6'h03;
	localparam logic [5:0] EXC_SUPERVISOR_CALL = 6'h0B;
	localparam logic [5:0] EXC_PENDABLE_SERVICE = 6'h0E;
	localparam logic [5:0] EXC_SYSTEM_TICK = 6'h0F;
	localparam logic [5:0] EXC_PERIPH_FIRST = 6'h10;
	localparam logic [31:0] VEC_STACK_ADDR = 32'h00000000;
	localparam logic [31:0] VEC_RESET_ADDR = 32'h00000004;
	localparam logic [31:0] VEC_NMI_ADDR = 32'h00000008;
	localparam logic [31:0] VEC_HARD_FAULT_ADDR = 32'h0000000C;
	localparam logic [31:0] SUPERVISOR_CALL_VECTOR = 32'h0000002C;
	localparam logic [31:0] PENDABLE_SERVICE_VECTOR = 32'h00000038;
	localparam logic [31:0] SYSTEM_TICK_VECTOR = 32'h0000003C;
	localparam logic [31:0] VEC_PERIPH_BASE = 32'h00000040;
	localparam logic [31:0] VEC_PERIPH_LAST = 32'h000000BC;
	localparam logic [4:0] RESERVED_LINE = 5'h1E;

	// fixed priorities of the system exceptions
	localparam logic signed [7:0] PRIO_STACK = 8'shF0;
	localparam logic signed [7:0] PRIO_RESET = 8'shF1;
	localparam logic signed [7:0] PRIO_NMI = 8'shF2;
	localparam logic signed [7:0] PRIO_HARD_FAULT = 8'shF3;
	localparam logic signed [7:0] PRIO_SUPERVISOR_CALL = 8'shFB;
	localparam logic signed [7:0] PRIO_PENDABLE_SERVICE = 8'shFE;
	localparam logic signed [7:0] PRIO_SYSTEM_TICK = 8'shFF;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic low_voltage_indicator_irq;
		logic system_clock_failure_irq;
		logic watchdog_irq;
		logic gpio_ab_irq;
		logic gpio_cd_irq;
		logic gpio_e_irq;
		logic gpio_f_irq;
		logic timer_10_irq;
		logic timer_11_irq;
		logic timer_12_irq;
		logic i2c_0_irq;
		logic serial_channel_a_irq;
		logic watch_timer_irq;
		logic timer_30_irq;
		logic i2c_1_irq;
		logic timer_20_irq;
		logic timer_21_irq;
		logic serial_channel_b_irq;
		logic converter_irq;
		logic uart_0_irq;
		logic uart_1_irq;
		logic timer_13_irq;
		logic timer_14_irq;
		logic timer_15_irq;
		logic timer_16_irq;
		logic i2c_2_irq;
		logic serial_channel_c_irq;
		logic serial_channel_d_irq;
		logic speech_codec_irq;
		logic dac_irq;
		logic led_irq;
		logic touch_irq;
		logic comparator_irq;
		logic crc_irq;
	} ivpm_src_s;

	typedef struct packed {
		logic [31:0] addr;
		logic signed [7:0] prio;
		logic used;
	} ivpm_vec_s;

	typedef struct packed {
		logic valid;
		logic [4:0] line;
		logic [1:0] prio;
	} ivpm_best_s;

endpackage : ivpm_pkg

// file: verilog/ivpm_prio_store.sv
// small priority memory: packed 2-bit fields, registered read port
`timescale 1ns/1ns
`default_nettype none
module ivpm_prio_store #(
	parameter int WORDS = 8,
	parameter int WIDTH = 8,
	parameter int IDX_W = 3
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [IDX_W-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data,
	output logic [WORDS*WIDTH-1:0] all_data
);
	logic [WIDTH-1:0] mem [WORDS];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < WORDS; i++) begin
				mem[i] <= '0;
			end
		end else if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem[rd_idx];
		end
	end

	always_comb begin
		for (int i = 0; i < WORDS; i++) begin
			all_data[i*WIDTH +: WIDTH] = mem[i];
		end
	end
endmodule : ivpm_prio_store
`default_nettype wire

// file: verilog/ivpm_map.sv
// interrupt vector map, line routing and per-line priority store
`timescale 1ns/1ns
`default_nettype none
module ivpm_map
	import ivpm_pkg::*;
#(
	parameter int LINES = 32
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire ivpm_src_s src,
	input wire logic vec_req,
	input wire logic [EXC_NUM_WIDTH-1:0] vec_num,
	output logic vec_ack,
	output ivpm_vec_s vec_ans,
	input wire logic prio_wr,
	input wire logic prio_rd,
	input wire logic [2:0] prio_idx,
	input wire logic [31:0] prio_wdata,
	output logic prio_rvalid,
	output logic [31:0] prio_rdata,
	output logic [LINES-1:0] irq_line,
	output ivpm_best_s best
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [7:0] pack_word(input logic [31:0] w);
		logic [7:0] p;
		p = '0;
		for (int s = 0; s < SLOTS_PER_WORD; s++) begin
			p[s*2 +: 2] = w[s*SLOT_WIDTH+PRIO_LSB +: PRIORITY_BIT_COUNT];
		end
		return p;
	endfunction : pack_word

	function automatic logic [31:0] unpack_word(input logic [7:0] p);
		logic [31:0] w;
		w = '0;
		for (int s = 0; s < SLOTS_PER_WORD; s++) begin
			w[s*SLOT_WIDTH+PRIO_LSB +: PRIORITY_BIT_COUNT] = p[s*2 +: 2];
		end
		return w;
	endfunction : unpack_word

	// ****************************************************************
	// source to line routing
	// ****************************************************************
	logic [LINES-1:0] next_irq_line;
	always_comb begin
		next_irq_line = '0;
		next_irq_line[0] = src.low_voltage_indicator_irq;
		next_irq_line[1] = src.system_clock_failure_irq;
		next_irq_line[2] = src.watchdog_irq;
		next_irq_line[3] = src.gpio_ab_irq;
		next_irq_line[4] = src.gpio_cd_irq;
		next_irq_line[5] = src.gpio_e_irq;
		next_irq_line[6] = src.gpio_f_irq;
		next_irq_line[7] = src.timer_10_irq;
		next_irq_line[8] = src.timer_11_irq;
		next_irq_line[9] = src.timer_12_irq;
		next_irq_line[10] = src.i2c_0_irq;
		next_irq_line[11] = src.serial_channel_a_irq;
		next_irq_line[12] = src.watch_timer_irq;
		next_irq_line[13] = src.timer_30_irq;
		next_irq_line[14] = src.i2c_1_irq;
		next_irq_line[15] = src.timer_20_irq;
		next_irq_line[16] = src.timer_21_irq;
		next_irq_line[17] = src.serial_channel_b_irq;
		next_irq_line[18] = src.converter_irq;
		next_irq_line[19] = src.uart_0_irq;
		next_irq_line[20] = src.uart_1_irq;
		next_irq_line[21] = src.timer_13_irq;
		next_irq_line[22] = src.timer_14_irq;
		next_irq_line[23] = src.timer_15_irq;
		next_irq_line[24] = src.timer_16_irq;
		next_irq_line[25] = src.i2c_2_irq;
		next_irq_line[26] = src.serial_channel_c_irq | src.serial_channel_d_irq;
		next_irq_line[27] = src.speech_codec_irq | src.dac_irq;
		next_irq_line[28] = src.led_irq;
		next_irq_line[29] = src.touch_irq;
		next_irq_line[31] = src.comparator_irq | src.crc_irq;
		next_irq_line[RESERVED_LINE] = 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_line <= '0;
		end else begin
			irq_line <= next_irq_line;
		end
	end

	// ****************************************************************
	// priority store, word-wide only
	// ****************************************************************
	logic [7:0] store_rd;
	logic [PRIO_WORDS*8-1:0] store_all;
	// only the top two bits of each byte are kept
	ivpm_prio_store #(.WORDS(PRIO_WORDS), .WIDTH(8), .IDX_W(3)) u_store (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wr_en(prio_wr),
		.wr_idx(prio_idx),
		.wr_data(pack_word(prio_wdata)),
		.rd_en(prio_rd),
		.rd_idx(prio_idx),
		.rd_data(store_rd),
		.all_data(store_all)
	);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prio_rvalid <= 1'b0;
		end else begin
			prio_rvalid <= prio_rd;
		end
	end

	// fields return in bits 7:6 of each byte
	assign prio_rdata = unpack_word(store_rd);

	// ****************************************************************
	// vector lookup
	// ****************************************************************
	// slot address, fixed or stored priority, used flag
	function automatic ivpm_vec_s lookup(input logic [5:0] num,
		input logic [PRIO_WORDS*8-1:0] all);
		ivpm_vec_s v;
		logic [4:0] ln;
		v.addr = {24'h000000, num, 2'h0};
		v.prio = 8'sh00;
		v.used = 1'b1;
		ln = 5'(num - EXC_PERIPH_FIRST);
		case (num)
			EXC_STACK: v.prio = PRIO_STACK;
			EXC_RESET: v.prio = PRIO_RESET;
			EXC_NMI: v.prio = PRIO_NMI;
			EXC_HARD_FAULT: v.prio = PRIO_HARD_FAULT;
			EXC_SUPERVISOR_CALL: v.prio = PRIO_SUPERVISOR_CALL;
			EXC_PENDABLE_SERVICE: v.prio = PRIO_PENDABLE_SERVICE;
			EXC_SYSTEM_TICK: v.prio = PRIO_SYSTEM_TICK;
			default: begin
				if (num >= EXC_PERIPH_FIRST && num < EXC_COUNT) begin
					v.prio = {6'h00, all[{ln, 1'b0} +: 2]};
					v.used = (ln != RESERVED_LINE);
				end else begin
					v.used = 1'b0;
				end
			end
		endcase
		return v;
	endfunction : lookup

	// vector table answer, one cycle after the request
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vec_ack <= 1'b0;
			vec_ans <= '0;
		end else begin
			vec_ack <= vec_req;
			if (vec_req) begin
				vec_ans <= lookup(vec_num, store_all);
			end
		end
	end

	// ****************************************************************
	// highest pending line
	// ****************************************************************
	ivpm_best_s next_best;
	// ties go to the lower line number, as the core resolves them
	always_comb begin
		next_best = '0;
		for (int i = LINES - 1; i >= 0; i--) begin
			if (irq_line[i] && (!next_best.valid ||
				store_all[i*2 +: 2] <= next_best.prio)) begin
				next_best.valid = 1'b1;
				next_best.line = 5'(i);
				next_best.prio = store_all[i*2 +: 2];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			best <= '0;
		end else begin
			best <= next_best;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_ask(logic [5:0] n);
		vec_req && vec_num == n;
	endsequence

	property p_reset_vec;
		s_ask(EXC_RESET) |=> vec_ack && vec_ans.addr == VEC_RESET_ADDR
			&& vec_ans.prio == PRIO_RESET;
	endproperty
	a_reset_vec: assert property (p_reset_vec)
		else $error("reset vector wrong");
	property p_nmi_vec;
		s_ask(EXC_NMI) |=> vec_ans.addr == VEC_NMI_ADDR
			&& vec_ans.prio == PRIO_NMI && vec_ans.used;
	endproperty
	a_nmi_vec: assert property (p_nmi_vec)
		else $error("nmi vector wrong");
	property p_tick_vec;
		s_ask(EXC_SYSTEM_TICK) |=> vec_ans.addr == SYSTEM_TICK_VECTOR
			&& vec_ans.prio == PRIO_SYSTEM_TICK;
	endproperty
	a_tick_vec: assert property (p_tick_vec)
		else $error("tick vector wrong");
	property p_periph_vec;
		vec_req && vec_num >= EXC_PERIPH_FIRST && vec_num < EXC_COUNT |=>
			vec_ans.addr == VEC_PERIPH_BASE
			+ 32'({$past(vec_num) - EXC_PERIPH_FIRST, 2'h0});
	endproperty
	a_periph_vec: assert property (p_periph_vec)
		else $error("line vector wrong");
	property p_reserved;
		s_ask(6'h2E) |=> !vec_ans.used;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved slot used");
	property p_reserved_line;
		!irq_line[RESERVED_LINE];
	endproperty
	a_reserved_line: assert property (p_reserved_line)
		else $error("reserved line raised");
	property p_watchdog_route;
		src.watchdog_irq |=> irq_line[2];
	endproperty
	a_watchdog_route: assert property (p_watchdog_route)
		else $error("line 2 lost");
	property p_timer30_route;
		$rose(src.timer_30_irq) |=> irq_line[13];
	endproperty
	a_timer30_route: assert property (p_timer30_route)
		else $error("line 13 lost");
	property p_uart1_route;
		!src.uart_1_irq |=> !irq_line[20];
	endproperty
	a_uart1_route: assert property (p_uart1_route)
		else $error("line 20 stray");
	property p_shared_or;
		(src.serial_channel_c_irq || src.serial_channel_d_irq) |=> irq_line[26];
	endproperty
	a_shared_or: assert property (p_shared_or)
		else $error("line 26 lost");

	sequence s_wr_then_rd;
		prio_wr && !prio_rd ##1 prio_rd && !prio_wr
			&& prio_idx == $past(prio_idx);
	endsequence
	property p_roundtrip;
		s_wr_then_rd |=> prio_rvalid
			&& prio_rdata == ($past(prio_wdata, 2) & PRIO_WORD_MASK);
	endproperty
	a_roundtrip: assert property (p_roundtrip)
		else $error("priority word lost");
	property p_low_bits_zero;
		prio_rvalid |-> (prio_rdata & ~PRIO_WORD_MASK) == 32'h00000000;
	endproperty
	a_low_bits_zero: assert property (p_low_bits_zero)
		else $error("low bits set");

endmodule : ivpm_map
`default_nettype wire

// file: tb/ivpm_core_model.sv
// processor-side model: vector fetches and word-wide priority access
`timescale 1ns/1ns
`default_nettype none
module ivpm_core_model
	import ivpm_pkg::*;
(
	input wire logic core_clk,
	output logic vec_req,
	output logic [EXC_NUM_WIDTH-1:0] vec_num,
	input wire logic vec_ack,
	input wire ivpm_vec_s vec_ans,
	output logic prio_wr,
	output logic prio_rd,
	output logic [2:0] prio_idx,
	output logic [31:0] prio_wdata,
	input wire logic prio_rvalid,
	input wire logic [31:0] prio_rdata
);
	initial begin
		vec_req = 1'b0;
		vec_num = '0;
		prio_wr = 1'b0;
		prio_rd = 1'b0;
		prio_idx = 3'h0;
		prio_wdata = 32'h0;
	end

	// ****************************************************************
	// requests
	// ****************************************************************
	// released lines show the inverse so a stale value cannot pass
	task automatic fetch(input logic [5:0] num, output ivpm_vec_s ans,
		output logic ok);
		int n;
		@(negedge core_clk);
		vec_req = 1'b1;
		vec_num = num;
		@(negedge core_clk);
		vec_req = 1'b0;
		vec_num = ~num;
		n = 0;
		while (vec_ack !== 1'b1 && n < 3) begin
			@(negedge core_clk);
			n++;
		end
		ok = (vec_ack === 1'b1);
		ans = vec_ans;
	endtask : fetch

	task automatic prio_write(input logic [2:0] idx, input logic [31:0] d);
		@(negedge core_clk);
		prio_wr = 1'b1;
		prio_idx = idx;
		prio_wdata = d;
		@(negedge core_clk);
		prio_wr = 1'b0;
		prio_idx = ~idx;
		prio_wdata = ~d;
	endtask : prio_write

	task automatic prio_write_read(input logic [2:0] idx,
		input logic [31:0] d, output logic [31:0] r, output logic ok);
		@(negedge core_clk);
		prio_wr = 1'b1;
		prio_idx = idx;
		prio_wdata = d;
		@(negedge core_clk);
		prio_wr = 1'b0;
		prio_rd = 1'b1;
		prio_wdata = ~d;
		@(negedge core_clk);
		prio_rd = 1'b0;
		prio_idx = ~idx;
		ok = (prio_rvalid === 1'b1);
		r = prio_rdata;
	endtask : prio_write_read

	task automatic prio_read(input logic [2:0] idx, output logic [31:0] d,
		output logic ok);
		int n;
		@(negedge core_clk);
		prio_rd = 1'b1;
		prio_idx = idx;
		@(negedge core_clk);
		prio_rd = 1'b0;
		prio_idx = ~idx;
		n = 0;
		while (prio_rvalid !== 1'b1 && n < 3) begin
			@(negedge core_clk);
			n++;
		end
		ok = (prio_rvalid === 1'b1);
		d = prio_rdata;
	endtask : prio_read
endmodule : ivpm_core_model
`default_nettype wire

// file: tb/tb_ivpm_map.sv
// self-checking bench for the interrupt vector and priority map
`timescale 1ns/1ns
`default_nettype none
module tb_ivpm_map;
	import ivpm_pkg::*;
	logic core_clk;
	logic rst_n;
	ivpm_src_s src;
	logic vec_req;
	logic [EXC_NUM_WIDTH-1:0] vec_num;
	logic vec_ack;
	ivpm_vec_s vec_ans;
	logic prio_wr;
	logic prio_rd;
	logic [2:0] prio_idx;
	logic [31:0] prio_wdata;
	logic prio_rvalid;
	logic [31:0] prio_rdata;
	logic [31:0] irq_line;
	ivpm_best_s best;
	int error_cnt;
	int total_checks;
	// line fed by each source field, counted from the top of the struct
	int line_of [34] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14,
		15, 16, 17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 26, 27, 27, 28, 29,
		31, 31};

	ivpm_map i_ivpm_map (.core_clk(core_clk), .rst_n(rst_n), .src(src),
		.vec_req(vec_req), .vec_num(vec_num), .vec_ack(vec_ack),
		.vec_ans(vec_ans), .prio_wr(prio_wr), .prio_rd(prio_rd),
		.prio_idx(prio_idx), .prio_wdata(prio_wdata),
		.prio_rvalid(prio_rvalid), .prio_rdata(prio_rdata),
		.irq_line(irq_line), .best(best));

	ivpm_core_model i_ivpm_core_model (.core_clk(core_clk),
		.vec_req(vec_req), .vec_num(vec_num), .vec_ack(vec_ack),
		.vec_ans(vec_ans), .prio_wr(prio_wr), .prio_rd(prio_rd),
		.prio_idx(prio_idx), .prio_wdata(prio_wdata),
		.prio_rvalid(prio_rvalid), .prio_rdata(prio_rdata));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [1:0] pv(input int n);
		return 2'((3 * n + 1) % 4);
	endfunction : pv

	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic tally_and_finish();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		logic [31:0] r;
		logic ok;
		check(vec_ack === 1'b0 && prio_rvalid === 1'b0, "strobe after reset");
		check(irq_line === 32'h0 && best === '0, "lines after reset");
		i_ivpm_core_model.prio_read(3'h5, r, ok);
		check(ok && r === 32'h0, "priority reset value");
	endtask : t_reset

	task automatic t_system();
		ivpm_vec_s a;
		logic ok;
		logic [15:0] used_set;
		// stack, reset, nmi, hard fault, call, pendable, tick
		used_set = 16'hC80F;
		for (int i = 0; i < 16; i++) begin
			i_ivpm_core_model.fetch(6'(i), a, ok);
			check(ok && a.addr === 32'(i * 4), "system address");
			check(a.used === used_set[i], "system used flag");
			if (used_set[i])
				check(a.prio === 8'(i - 16), "fixed priority");
		end
		i_ivpm_core_model.fetch(6'h30, a, ok);
		check(ok && a.used === 1'b0, "slot past table");
	endtask : t_system

	task automatic t_lines();
		ivpm_vec_s a;
		logic ok;
		logic [31:0] w;
		logic [31:0] r;
		i_ivpm_core_model.prio_write(3'h0, 32'hFFFFFFFF);
		i_ivpm_core_model.prio_read(3'h0, r, ok);
		check(ok && r === 32'hC0C0C0C0, "low priority bits");
		for (int k = 0; k < 8; k++) begin
			for (int s = 0; s < 4; s++) w[8*s +: 8] = {pv(4 * k + s), 6'h2A};
			i_ivpm_core_model.prio_write(3'(k), w);
		end
		for (int k = 0; k < 8; k++) begin
			for (int s = 0; s < 4; s++) w[8*s +: 8] = {pv(4 * k + s), 6'h00};
			i_ivpm_core_model.prio_read(3'(k), r, ok);
			check(ok && r === w, "priority word readback");
		end
		for (int n = 0; n < 32; n++) begin
			i_ivpm_core_model.fetch(6'(16 + n), a, ok);
			check(ok && a.addr === 32'h40 + 32'(4 * n), "line vector");
			check(a.used === (n != 30), "line used flag");
			if (n != 30)
				check(a.prio === 8'(pv(n)), "line priority");
		end
	endtask : t_lines

	task automatic t_route();
		ivpm_best_s b;
		for (int j = 0; j < 34; j++) begin
			src = 34'h1 << (33 - j);
			repeat (3) @(negedge core_clk);
			check(irq_line === 32'h1 << line_of[j], "routing");
			b = '{1'b1, 5'(line_of[j]), pv(line_of[j])};
			check(best === b, "single pending line");
		end
		src = '1;
		repeat (3) @(negedge core_clk);
		check(irq_line === 32'hBFFFFFFF, "all sources");
		src = '0;
	endtask : t_route

	task automatic t_best();
		// lines 2 and 3 hold priorities 3 and 2
		src.watchdog_irq = 1'b1;
		src.gpio_ab_irq = 1'b1;
		repeat (3) @(negedge core_clk);
		check(best === ivpm_best_s'{1'b1, 5'd3, 2'd2}, "lower wins");
		// lines 0 and 4 both hold priority 1
		src = '0;
		src.low_voltage_indicator_irq = 1'b1;
		src.gpio_cd_irq = 1'b1;
		repeat (3) @(negedge core_clk);
		check(best === ivpm_best_s'{1'b1, 5'd0, 2'd1}, "tie");
		src = '0;
		repeat (3) @(negedge core_clk);
		check(best.valid === 1'b0, "nothing pending");
	endtask : t_best

	task automatic t_back_to_back();
		ivpm_vec_s a;
		logic [31:0] r;
		logic ok;
		i_ivpm_core_model.prio_write_read(3'h7, 32'h5A96C3FF, r, ok);
		check(ok && r === 32'h4080C0C0, "read after write");
		i_ivpm_core_model.fetch(6'h2C, a, ok);
		check(ok && a.used === 1'b1 && a.prio === 8'h03, "new word");
	endtask : t_back_to_back

	initial begin
		error_cnt = 0;
		total_checks = 0;
		src = '0;
		rst_n = 1'b0;
		repeat (5) @(negedge core_clk);
		rst_n = 1'b1;
		t_reset();
		t_system();
		t_lines();
		t_route();
		t_best();
		t_back_to_back();
		tally_and_finish();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
endmodule : tb_ivpm_map
`default_nettype wire
